/* File: acpm_pkg.sv */
/*
 * Shared constants and types of the accelerometer power-mode controller:
 * register offsets, field positions, reset values, carrier structs, mode
 * and phase encodings and the sleep-length table.
 * Assumes a 50 MHz system clock and 8-bit register data.
 */
`default_nettype none

package acpm_pkg;

    // ------------------------------
    // Clock
    // ------------------------------
    localparam int unsigned CLK_FREQ_MHZ = 50;

    // ------------------------------
    // Register offsets
    // ------------------------------
    localparam logic [7:0] OFS_MODE     = 8'h11;
    localparam logic [7:0] OFS_LPCFG    = 8'h12;
    localparam logic [7:0] OFS_SOFTRST  = 8'h14;
    localparam logic [7:0] OFS_IRQPIN   = 8'h20;
    localparam logic [7:0] OFS_QSETUP_A = 8'h30;
    localparam logic [7:0] OFS_IFCFG    = 8'h34;
    localparam logic [7:0] OFS_QSETUP_B = 8'h3E;
    localparam logic [7:0] OFS_QPORT    = 8'h3F;

    // Arbitrary value: writing it to the soft-reset offset resets all
    localparam logic [7:0] SOFTRST_CODE = 8'hA5;

    // ------------------------------
    // Field positions
    // ------------------------------
    localparam int unsigned MODE_DEEP_BIT = 7;
    localparam int unsigned MODE_LPEN_BIT = 6;
    localparam int unsigned MODE_SUSP_BIT = 5;
    localparam int unsigned MODE_DUR_LSB  = 1;
    localparam int unsigned LP_FLAV_BIT   = 6;
    localparam int unsigned LP_TMR_BIT    = 5;
    localparam int unsigned IF_3W_BIT     = 0;
    localparam int unsigned IF_WSEL_BIT   = 1;
    localparam int unsigned IF_WEN_BIT    = 2;
    localparam int unsigned IRQ_A_LVL_BIT = 0;
    localparam int unsigned IRQ_A_OD_BIT  = 1;
    localparam int unsigned IRQ_B_LVL_BIT = 2;
    localparam int unsigned IRQ_B_OD_BIT  = 3;

    // ------------------------------
    // Writable masks and reset values
    // ------------------------------
    localparam logic [7:0] MODE_MASK   = 8'hFE;
    localparam logic [7:0] LPCFG_MASK  = 8'h60;
    localparam logic [7:0] IFCFG_MASK  = 8'h07;
    localparam logic [7:0] IRQPIN_MASK = 8'h0F;
    localparam logic [7:0] MODE_RST    = 8'h00;
    localparam logic [7:0] LPCFG_RST   = 8'h00;
    localparam logic [7:0] IFCFG_RST   = 8'h00;
    localparam logic [7:0] IRQPIN_RST  = 8'h00;
    localparam logic [7:0] QSETUP_RST  = 8'h00;
    localparam logic [7:0] MODE_DEEP_SET = 8'(1) << MODE_DEEP_BIT;

    // ------------------------------
    // Carriers and encodings
    // ------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acpm_req_t;

    typedef struct packed {
        logic       valid;
        logic       refused;
        logic [7:0] rdata;
    } acpm_rsp_t;

    typedef enum logic [5:0] {
        PM_NORMAL = 6'b000001,
        PM_DEEP   = 6'b000010,
        PM_SUSP   = 6'b000100,
        PM_STBY   = 6'b001000,
        PM_LP1    = 6'b010000,
        PM_LP2    = 6'b100000
    } acpm_mode_t;

    typedef enum logic [1:0] {
        PH_WAKE  = 2'b01,
        PH_SLEEP = 2'b10
    } acpm_phase_t;

    // ------------------------------
    // Sleep-phase length in microseconds per four-bit code
    // ------------------------------
    function automatic logic [19:0] acpm_sleep_us(input logic [3:0] code);
        logic [19:0] us;
        case (code)
            4'h6:    us = 20'd1000;
            4'h7:    us = 20'd2000;
            4'h8:    us = 20'd4000;
            4'h9:    us = 20'd6000;
            4'hA:    us = 20'd10000;
            4'hB:    us = 20'd25000;
            4'hC:    us = 20'd50000;
            4'hD:    us = 20'd100000;
            4'hE:    us = 20'd500000;
            4'hF:    us = 20'd1000000;
            default: us = 20'd500;
        endcase
        return us;
    endfunction

endpackage

`default_nettype wire

/* File: acpm_ctrl.sv */
/*
 * Accelerometer power-mode controller: register slice for the mode bits,
 * access gating per power mode, low-power wake/sleep sequencer and power
 * gating outputs.
 * Assumes the serial interface front end presents one register request
 * per cycle on reg_req, and that acquisition and interrupt engines run
 * on clk_sys. reset_n is the power-on reset of both supplies.
 */
//
// Contract
// - Leave reset in normal mode, acquisition running
// - Six power modes exactly
// - Power-on reset restores every register default
// - Deep-suspend: interface only, configuration lost
// - Deep bit toggles deep-suspend when suspend clear
// - Deep-suspend keeps watchdog, three-wire, deep bits
// - Deep-suspend keeps interrupt pin configuration accessible
// - Soft reset returns low modes to normal
// - Suspend: analog off, data and configuration kept
// - Suspend refuses queue setup and queue port
// - Suspend bit with flavour zero selects suspend
// - Standby: analog off, digital alive, full access
// - Suspend bit with flavour one selects standby
// - Low-power 1 alternates wake and suspend-like sleep
// - Low-power 1 queue port unreadable, sleep restricted
// - Low-power 2 standby-like sleep, unrestricted access
// - Event timing: wake lasts required sample count
// - Detected interrupt holds wake phase
// - Sleep once samples done and bus idle
// - Timer select one gives equidistant wake starts, sleep fills the rest
// - Four-bit code sets sleep-phase length
`default_nettype none

module acpm_ctrl #(
    parameter int unsigned CLK_PER_US = acpm_pkg::CLK_FREQ_MHZ,
    parameter int unsigned SMP_W      = 4
) (
    // Clock and power-on reset
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    // Register access from the serial interface
    input  wire acpm_pkg::acpm_req_t reg_req,
    output acpm_pkg::acpm_rsp_t      reg_rsp,
    input  wire logic [7:0]          queue_data,
    output logic                     queue_pop,
    // Protocol strap
    input  wire logic                protocol_select_pin,
    output logic                     proto_is_i2c,
    // Acquisition and interrupt engines
    input  wire logic                sample_tick,
    input  wire logic [SMP_W-1:0]    samples_needed,
    input  wire logic                irq_hold,
    input  wire logic                bus_busy,
    // Power state
    output acpm_pkg::acpm_mode_t     power_mode,
    output logic                     analog_pwr_en,
    output logic                     digital_pwr_en,
    output logic                     acq_run,
    output logic                     wake_phase,
    // Configuration to interface and pins
    output logic                     three_wire_select,
    output logic                     wdt_en,
    output logic                     wdt_sel,
    output logic                     irq_a_active_level,
    output logic                     irq_a_open_drain,
    output logic                     irq_b_active_level,
    output logic                     irq_b_open_drain,
    output logic [7:0]               queue_setup_a,
    output logic [7:0]               queue_setup_b
);

    // ------------------------------
    // Registers
    // ------------------------------
    logic [7:0]            mode_q, mode_d;
    logic [7:0]            lpcfg_q, lpcfg_d;
    logic [7:0]            ifcfg_q, ifcfg_d;
    logic [7:0]            irqpin_q, irqpin_d;
    logic [7:0]            qa_q, qa_d;
    logic [7:0]            qb_q, qb_d;
    acpm_pkg::acpm_phase_t phase_q, phase_d;
    logic [31:0]           timer_q, timer_d;
    logic [SMP_W-1:0]      cnt_q, cnt_d;
    logic [1:0]            ps_sync_q;
    logic [1:0]            settle_q;
    logic                  proto_q;
    acpm_pkg::acpm_rsp_t   rsp_q;
    logic                  pop_q;
    acpm_pkg::acpm_mode_t  pm_q;
    logic                  ana_q, dig_q, wake_q;

    // ------------------------------
    // Protocol strap: synchronised, caught once after reset release
    // ------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ps_sync_q <= 2'h0;
            settle_q  <= 2'h0;
            proto_q   <= 1'b0;
        end else begin
            ps_sync_q <= {ps_sync_q[0], protocol_select_pin};
            if (settle_q != 2'h3) begin
                settle_q <= settle_q + 2'h1;
            end
            if (settle_q == 2'h2) begin
                proto_q <= ps_sync_q[1];
            end
        end
    end

    // ------------------------------
    // Mode decode
    // ------------------------------
    wire bit_deep = mode_q[acpm_pkg::MODE_DEEP_BIT];
    wire bit_susp = mode_q[acpm_pkg::MODE_SUSP_BIT];
    wire bit_lpen = mode_q[acpm_pkg::MODE_LPEN_BIT];
    wire bit_flav = lpcfg_q[acpm_pkg::LP_FLAV_BIT];
    wire bit_est  = lpcfg_q[acpm_pkg::LP_TMR_BIT];

    // Deep outranks suspend, suspend outranks the duty-cycle modes
    acpm_pkg::acpm_mode_t mode_dec;
    assign mode_dec = bit_deep ? acpm_pkg::PM_DEEP :
                      bit_susp ? (bit_flav ? acpm_pkg::PM_STBY
                                           : acpm_pkg::PM_SUSP)
                    : bit_lpen ? (bit_flav ? acpm_pkg::PM_LP2
                                           : acpm_pkg::PM_LP1)
                    : acpm_pkg::PM_NORMAL;

    wire m_deep = (mode_dec == acpm_pkg::PM_DEEP);
    wire m_susp = (mode_dec == acpm_pkg::PM_SUSP);
    wire m_lp1  = (mode_dec == acpm_pkg::PM_LP1);
    wire m_lp2  = (mode_dec == acpm_pkg::PM_LP2);
    wire in_lp  = m_lp1 | m_lp2;
    wire asleep = in_lp & (phase_q == acpm_pkg::PH_SLEEP);

    // ------------------------------
    // Access gating
    // ------------------------------
    wire [7:0] addr   = reg_req.addr;
    wire [7:0] wdata  = reg_req.wdata;
    wire       a_mode = (addr == acpm_pkg::OFS_MODE);
    wire       a_lp   = (addr == acpm_pkg::OFS_LPCFG);
    wire       a_srst = (addr == acpm_pkg::OFS_SOFTRST);
    wire       a_irq  = (addr == acpm_pkg::OFS_IRQPIN);
    wire       a_if   = (addr == acpm_pkg::OFS_IFCFG);
    wire       a_qa   = (addr == acpm_pkg::OFS_QSETUP_A);
    wire       a_qb   = (addr == acpm_pkg::OFS_QSETUP_B);
    wire       a_qp   = (addr == acpm_pkg::OFS_QPORT);

    // Only the mode, soft-reset, interface section and interrupt pin setup registers answer in deep-suspend
    wire deep_ok   = a_mode | a_if | a_irq | a_srst;
    // Low-power 1 outside its wake phase behaves like suspend
    wire susp_like = m_susp | (m_lp1 & asleep);
    wire refuse    = (m_deep & ~deep_ok)
                   | (susp_like & (a_qa | a_qb | a_qp))
                   | (m_lp1 & reg_req.rd & a_qp);
    wire acc       = reg_req.rd | reg_req.wr;
    wire wr_ok     = reg_req.wr & ~refuse;
    wire rd_ok     = reg_req.rd & ~refuse;

    wire soft_rst   = wr_ok & a_srst & (wdata == acpm_pkg::SOFTRST_CODE);
    wire wr_mode    = wr_ok & a_mode;
    wire new_deep   = wdata[acpm_pkg::MODE_DEEP_BIT];
    wire new_susp   = wdata[acpm_pkg::MODE_SUSP_BIT];
    wire enter_deep = wr_mode & ~bit_deep & new_deep & ~new_susp;
    wire wipe_cfg   = soft_rst | enter_deep;

    // ------------------------------
    // Register next values
    // ------------------------------
    // In deep-suspend only the deep bit of the mode register works
    assign mode_d =
        soft_rst           ? acpm_pkg::MODE_RST :
        (wr_mode & bit_deep) ? (new_deep ? mode_q
                                         : acpm_pkg::MODE_RST) :
        enter_deep         ? acpm_pkg::MODE_DEEP_SET :
        wr_mode            ? (wdata & acpm_pkg::MODE_MASK
                              & ~acpm_pkg::MODE_DEEP_SET) :
        mode_q;

    assign lpcfg_d = wipe_cfg ? acpm_pkg::LPCFG_RST :
                     (wr_ok & a_lp) ? (wdata & acpm_pkg::LPCFG_MASK) :
                     lpcfg_q;
    assign qa_d    = wipe_cfg ? acpm_pkg::QSETUP_RST :
                     (wr_ok & a_qa) ? wdata : qa_q;
    assign qb_d    = wipe_cfg ? acpm_pkg::QSETUP_RST :
                     (wr_ok & a_qb) ? wdata : qb_q;
    // Interface and pin setup survive deep-suspend
    assign ifcfg_d  = soft_rst ? acpm_pkg::IFCFG_RST :
                      (wr_ok & a_if) ? (wdata & acpm_pkg::IFCFG_MASK) :
                      ifcfg_q;
    assign irqpin_d = soft_rst ? acpm_pkg::IRQPIN_RST :
                      (wr_ok & a_irq) ? (wdata & acpm_pkg::IRQPIN_MASK) :
                      irqpin_q;

    // Soft-reset offset is write-only and reads as zero
    wire [7:0] rd_sel = a_mode ? mode_q  :
                        a_lp   ? lpcfg_q :
                        a_irq  ? irqpin_q :
                        a_if   ? ifcfg_q :
                        a_qa   ? qa_q    :
                        a_qb   ? qb_q    :
                        a_qp   ? queue_data : 8'h00;

    acpm_pkg::acpm_rsp_t rsp_d;
    assign rsp_d = '{acc, acc & refuse, rd_ok ? rd_sel : 8'h00};

    // ------------------------------
    // Low-power wake/sleep sequencer
    // ------------------------------
    wire [31:0] sleep_cyc = 32'(acpm_pkg::acpm_sleep_us(
        mode_q[acpm_pkg::MODE_DUR_LSB +: 4]) * CLK_PER_US);
    wire [SMP_W-1:0] need_n = (samples_needed == '0) ? SMP_W'(1)
                                                     : samples_needed;
    wire cnt_full  = (cnt_q == {SMP_W{1'b1}});
    // Interrupts and an open bus cycle both stretch the wake phase
    wire wake_done = (cnt_q >= need_n)
                   & ~irq_hold
                   & ~bus_busy;

    always_comb begin
        phase_d = phase_q;
        timer_d = timer_q;
        cnt_d   = cnt_q;
        if (!in_lp) begin
            phase_d = acpm_pkg::PH_WAKE;
            timer_d = sleep_cyc - 32'd1;
            cnt_d   = '0;
        end else begin
            unique case (phase_q)
                acpm_pkg::PH_WAKE: begin
                    if (sample_tick && !cnt_full) begin
                        cnt_d = cnt_q + SMP_W'(1);
                    end
                    // Equidistant timer runs from wake start
                    if (bit_est && timer_q != 32'd0) begin
                        timer_d = timer_q - 32'd1;
                    end
                    if (wake_done) begin
                        phase_d = acpm_pkg::PH_SLEEP;
                        cnt_d   = '0;
                        if (!bit_est) begin
                            timer_d = sleep_cyc - 32'd1;
                        end
                    end
                end
                acpm_pkg::PH_SLEEP: begin
                    if (timer_q == 32'd0) begin
                        phase_d = acpm_pkg::PH_WAKE;
                        timer_d = sleep_cyc - 32'd1;
                    end else begin
                        timer_d = timer_q - 32'd1;
                    end
                end
                default: begin
                    phase_d = acpm_pkg::PH_WAKE;
                end
            endcase
        end
    end

    // ------------------------------
    // Power gating
    // ------------------------------
    wire lp_awake = in_lp & (phase_q == acpm_pkg::PH_WAKE);
    // Analog runs only in normal or a wake phase; standby keeps digital
    wire ana_d = (mode_dec == acpm_pkg::PM_NORMAL) | lp_awake;
    wire dig_d = ~(m_deep | m_susp | (m_lp1 & asleep));

    // ------------------------------
    // Flip-flops
    // ------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q   <= acpm_pkg::MODE_RST;
            lpcfg_q  <= acpm_pkg::LPCFG_RST;
            ifcfg_q  <= acpm_pkg::IFCFG_RST;
            irqpin_q <= acpm_pkg::IRQPIN_RST;
            qa_q     <= acpm_pkg::QSETUP_RST;
            qb_q     <= acpm_pkg::QSETUP_RST;
        end else begin
            mode_q   <= mode_d;
            lpcfg_q  <= lpcfg_d;
            ifcfg_q  <= ifcfg_d;
            irqpin_q <= irqpin_d;
            qa_q     <= qa_d;
            qb_q     <= qb_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= acpm_pkg::PH_WAKE;
            timer_q <= 32'd0;
            cnt_q   <= '0;
        end else begin
            phase_q <= phase_d;
            timer_q <= timer_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rsp_q  <= '0;
            pop_q  <= 1'b0;
            pm_q   <= acpm_pkg::PM_NORMAL;
            ana_q  <= 1'b1;
            dig_q  <= 1'b1;
            wake_q <= 1'b0;
        end else begin
            rsp_q  <= rsp_d;
            pop_q  <= rd_ok & a_qp;
            pm_q   <= mode_dec;
            ana_q  <= ana_d;
            dig_q  <= dig_d;
            wake_q <= lp_awake;
        end
    end

    // ------------------------------
    // Outputs
    // ------------------------------
    assign reg_rsp            = rsp_q;
    assign queue_pop          = pop_q;
    assign proto_is_i2c       = proto_q;
    assign power_mode         = pm_q;
    assign analog_pwr_en      = ana_q;
    assign digital_pwr_en     = dig_q;
    assign acq_run            = ana_q;
    assign wake_phase         = wake_q;
    assign three_wire_select  = ifcfg_q[acpm_pkg::IF_3W_BIT];
    assign wdt_en             = ifcfg_q[acpm_pkg::IF_WEN_BIT];
    assign wdt_sel            = ifcfg_q[acpm_pkg::IF_WSEL_BIT];
    assign irq_a_active_level = irqpin_q[acpm_pkg::IRQ_A_LVL_BIT];
    assign irq_a_open_drain   = irqpin_q[acpm_pkg::IRQ_A_OD_BIT];
    assign irq_b_active_level = irqpin_q[acpm_pkg::IRQ_B_LVL_BIT];
    assign irq_b_open_drain   = irqpin_q[acpm_pkg::IRQ_B_OD_BIT];
    assign queue_setup_a      = qa_q;
    assign queue_setup_b      = qb_q;

endmodule // acpm_ctrl

`default_nettype wire

/* File: acpm_ctrl_asserts.sv */
/* Port checker of the accelerometer power-mode controller.
   Bound to acpm_ctrl; one clock domain, asynchronous low reset. */
`default_nettype none
module acpm_ctrl_asserts #(
    parameter int unsigned CLK_PER_US = 50,
    parameter int unsigned SMP_W      = 4
) (
    // Clock, reset and register bus
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    input wire acpm_pkg::acpm_req_t  reg_req,
    input wire acpm_pkg::acpm_rsp_t  reg_rsp,
    input wire logic [7:0]           queue_data,
    input wire logic                 queue_pop,
    // Power state
    input wire logic                 irq_hold,
    input wire acpm_pkg::acpm_mode_t power_mode,
    input wire logic                 analog_pwr_en,
    input wire logic                 digital_pwr_en,
    input wire logic                 acq_run,
    input wire logic                 wake_phase
);
    wire req     = reg_req.rd | reg_req.wr;
    wire m_norm  = power_mode == acpm_pkg::PM_NORMAL;
    wire m_deep  = power_mode == acpm_pkg::PM_DEEP;
    wire m_susp  = power_mode == acpm_pkg::PM_SUSP;
    wire m_stby  = power_mode == acpm_pkg::PM_STBY;
    wire m_lp1   = power_mode == acpm_pkg::PM_LP1;
    wire m_lp    = m_lp1 | (power_mode == acpm_pkg::PM_LP2);
    wire port_rd = reg_req.rd & (reg_req.addr == 8'h3F);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_rsp_next: assert property (req |=> reg_rsp.valid)
        else $error("no response after request");
    a_rsp_quiet: assert property (
        !req |=> !reg_rsp.valid && !queue_pop)
        else $error("response without request");
    a_reset_normal: assert property ($rose(reset_n) |-> m_norm)
        else $error("not normal after reset");
    a_normal_power: assert property (
        m_norm |-> analog_pwr_en && digital_pwr_en && acq_run && !wake_phase)
        else $error("normal mode not fully powered");
    a_low_analog: assert property (
        m_deep || m_susp || m_stby |-> !analog_pwr_en && !acq_run
            && digital_pwr_en == m_stby)
        else $error("power gating wrong in low mode");
    a_lp_phase_pwr: assert property (
        m_lp |-> analog_pwr_en == wake_phase
            && digital_pwr_en == (wake_phase || !m_lp1))
        else $error("power gating wrong in low-power phase");
    a_susp_gate: assert property (
        req && m_susp |=> reg_rsp.refused ==
            ($past(reg_req.addr) inside {8'h30, 8'h3E, 8'h3F}))
        else $error("suspend access gating wrong");
    a_deep_gate: assert property (
        req && m_deep |=> reg_rsp.refused !=
            ($past(reg_req.addr) inside {8'h11, 8'h14, 8'h20, 8'h34}))
        else $error("deep-suspend access gating wrong");
    a_stby_open: assert property (
        req && (m_stby || (m_lp && !m_lp1)) |=> !reg_rsp.refused)
        else $error("access refused in open mode");
    a_lp1_port: assert property (
        port_rd && m_lp1 |=> reg_rsp.refused && !queue_pop)
        else $error("queue port read in low-power 1");
    a_port_read: assert property (
        port_rd && (m_norm || m_stby)
            |=> queue_pop && reg_rsp.rdata == $past(queue_data))
        else $error("queue port read wrong");
    a_soft_reset: assert property (
        reg_req.wr && reg_req.addr == 8'h14 && reg_req.wdata == 8'hA5
            |-> ##2 m_norm)
        else $error("soft reset did not give normal mode");
    a_irq_hold: assert property (
        m_lp && wake_phase && irq_hold |=> wake_phase || !m_lp)
        else $error("wake phase ended under interrupt");

    c_deep: cover property (m_deep);
    c_lp1_sleep: cover property (m_lp1 && !wake_phase);
    c_refused: cover property (reg_rsp.valid && reg_rsp.refused);
endmodule // acpm_ctrl_asserts

bind acpm_ctrl acpm_ctrl_asserts #(.CLK_PER_US(CLK_PER_US), .SMP_W(SMP_W))
    chk_u (.clk_sys, .reset_n, .reg_req, .reg_rsp, .queue_data, .queue_pop,
    .irq_hold, .power_mode, .analog_pwr_en, .digital_pwr_en, .acq_run,
    .wake_phase);
`default_nettype wire

/* File: acpm_host_model.sv */
/* Host model: issues single register requests to the controller.
   Assumes the caller enters access just after a falling clock edge. */
`default_nettype none
module acpm_host_model (
    // Register bus
    input  wire logic                clk_sys,
    output var acpm_pkg::acpm_req_t  reg_req,
    input  wire acpm_pkg::acpm_rsp_t reg_rsp
);
    initial reg_req = '0;

    task automatic access(input logic wr, input logic [7:0] addr,
        input logic [7:0] wdata, output acpm_pkg::acpm_rsp_t rsp);
        reg_req = '{~wr, wr, addr, wdata};
        @(posedge clk_sys);
        @(negedge clk_sys);
        rsp = reg_rsp;
        reg_req = '0;
        // Idle cycle after a write keeps slow suspend timing safe
        if (wr) @(negedge clk_sys);
    endtask
endmodule // acpm_host_model
`default_nettype wire

/* File: acpm_ctrl_tb_top.sv */
/* Self-checking bench of the power-mode controller.
   Assumes the host model and bound checker; sleep timer scaled to 1/us. */
`default_nettype none
module acpm_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } acpm_row_t;
    logic                 clk_sys = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 tick = 1'b0;
    logic [3:0]           need = 4'h2;
    logic                 irq_hold = 1'b0;
    logic                 bus_busy = 1'b0;
    logic [6:0]           pins;
    acpm_pkg::acpm_req_t  reg_req;
    acpm_pkg::acpm_rsp_t  reg_rsp;
    acpm_pkg::acpm_rsp_t  rsp;
    acpm_pkg::acpm_mode_t pm;
    logic                 ana;
    logic                 dig;
    logic                 wake;
    logic                 proto;
    int                   fails = 0;
    int                   tests_run = 0;
    int                   n;
    acpm_row_t rows [12] = '{'{0, 8'h11, 0, 0}, '{0, 8'h12, 0, 0},
        '{0, 8'h20, 0, 0}, '{0, 8'h34, 0, 0}, '{0, 8'h30, 0, 0},
        '{0, 8'h3E, 0, 0}, '{1, 8'h20, 8'hFF, 8'h0F},
        '{1, 8'h34, 8'hFF, 8'h07}, '{1, 8'h30, 8'h5A, 8'h5A},
        '{1, 8'h3E, 8'hC3, 8'hC3}, '{1, 8'h55, 8'hFF, 8'h00},
        '{0, 8'h3F, 0, 8'h3C}};

    acpm_host_model host_u (.clk_sys, .reg_req, .reg_rsp);
    // I2C strap tied high
    acpm_ctrl #(.CLK_PER_US(1), .SMP_W(4)) dut_u (.clk_sys, .reset_n,
        .reg_req, .reg_rsp, .queue_data(8'h3C), .queue_pop(),
        .protocol_select_pin(1'b1), .proto_is_i2c(proto),
        .sample_tick(tick), .samples_needed(need), .irq_hold, .bus_busy,
        .power_mode(pm),
        .analog_pwr_en(ana), .digital_pwr_en(dig), .acq_run(),
        .wake_phase(wake), .three_wire_select(pins[0]), .wdt_en(pins[2]),
        .wdt_sel(pins[1]), .irq_a_active_level(pins[3]),
        .irq_a_open_drain(pins[4]), .irq_b_active_level(pins[5]),
        .irq_b_open_drain(pins[6]), .queue_setup_a(), .queue_setup_b());

    task automatic tally_and_finish;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d, rsp);
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e,
        input logic r);
        host_u.access(1'b0, a, 8'h00, rsp);
        check(rsp.valid === 1'b1 && rsp.refused === r && rsp.rdata === e,
            $sformatf("read of %h", a));
    endtask
    // Bounded wait for a wake level; running out ends the run
    task automatic wait_wake(input logic v, input int lim);
        n = 0;
        while (wake !== v) begin
            @(negedge clk_sys);
            n++;
            if (n > lim) begin
                fails++;
                tally_and_finish();
            end
        end
    endtask

    initial forever #10 clk_sys = ~clk_sys;
    initial begin
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
            rd_exp(rows[i].addr, rows[i].rexp, 1'b0);
        end
        check(pins === 7'h7F, "pin configuration");
        check(proto === 1'b1, "strap");
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h20);
        check(pm === acpm_pkg::PM_SUSP && ana === 1'b0, "suspend");
        host_u.access(1'b1, 8'h30, 8'h11, rsp);
        check(rsp.refused === 1'b1, "queue setup write");
        rd_exp(8'h3F, 8'h00, 1'b1);
        rd_exp(8'h20, 8'h0F, 1'b0);
        wr(8'h11, 8'h00);
        rd_exp(8'h30, 8'h5A, 1'b0);
        wr(8'h12, 8'h40);
        wr(8'h11, 8'h20);
        check(pm === acpm_pkg::PM_STBY && dig === 1'b1, "standby");
        wr(8'h3E, 8'h77);
        rd_exp(8'h3E, 8'h77, 1'b0);
        wr(8'h14, 8'hA5);
        check(pm === acpm_pkg::PM_NORMAL, "soft reset");
        rd_exp(8'h3E, 8'h00, 1'b0);
        wr(8'h30, 8'h5A);
        wr(8'h20, 8'h0F);
        wr(8'h11, 8'h80);
        check(pm === acpm_pkg::PM_DEEP, "deep entry");
        rd_exp(8'h30, 8'h00, 1'b1);
        wr(8'h34, 8'h07);
        rd_exp(8'h20, 8'h0F, 1'b0);
        check(pins === 7'h7F, "pins in deep");
        wr(8'h11, 8'h00);
        check(pm === acpm_pkg::PM_NORMAL, "deep exit");
        rd_exp(8'h30, 8'h00, 1'b0);
        irq_hold = 1'b1;
        wr(8'h11, 8'h40);
        tick = 1'b1;
        repeat (3) @(negedge clk_sys);
        tick = 1'b0;
        repeat (8) @(negedge clk_sys);
        check(pm === acpm_pkg::PM_LP1 && wake === 1'b1, "held");
        irq_hold = 1'b0;
        bus_busy = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(wake === 1'b1, "busy keeps wake");
        bus_busy = 1'b0;
        wait_wake(1'b0, 8);
        check(ana === 1'b0 && dig === 1'b0, "sleep power");
        wait_wake(1'b1, 600);
        check(n >= 499 && n <= 501, "sleep length");
        rd_exp(8'h3F, 8'h00, 1'b1);
        need = 4'h1;
        wr(8'h12, 8'h40);
        check(pm === acpm_pkg::PM_LP2, "low-power 2");
        tick = 1'b1;
        @(negedge clk_sys);
        tick = 1'b0;
        wait_wake(1'b0, 8);
        check(dig === 1'b1, "standby-like sleep");
        rd_exp(8'h30, 8'h00, 1'b0);
        wr(8'h20, 8'h0F);
        reset_n = 1'b0;
        @(negedge clk_sys);
        reset_n = 1'b1;
        check(pm === acpm_pkg::PM_NORMAL, "mid-run reset");
        rd_exp(8'h20, 8'h00, 1'b0);
        tally_and_finish();
    end
endmodule // acpm_ctrl_tb_top
`default_nettype wire
